// [shared/float_range_pkg.sv]
/*
 Package for the floating range exception control block: widths, field
 positions, exponent offset and the carrier structs.
 Assumes a float of sign, 8-bit excess-200 (octal) exponent and fraction.
*/
package float_range_pkg;
	localparam int FRAC_W = 55;
	localparam int EXP_W = 8;
	localparam int TOTAL_W = 1 + EXP_W + FRAC_W;
	localparam int EXP_INT_W = 11;
	// Status word bit positions of the two trap enables
	localparam int UNDERFLOW_TRAP_BIT = 10;
	localparam int OVERFLOW_TRAP_BIT = 9;
	// Exponent offset applied on an enabled range exception (400 octal)
	localparam logic [EXP_INT_W-1:0] EXP_WRAP = 11'h100;
	localparam logic [EXP_INT_W-1:0] EXP_MAX = 11'h0FF;
	localparam logic [TOTAL_W-1:0] RESULT_RESET = 64'h0000000000000000;

	// Raw result from the arithmetic stage, exponent unbounded and signed
	typedef struct packed {
		logic valid;
		logic sign;
		logic [EXP_INT_W-1:0] exp;
		logic [FRAC_W-1:0] frac;
		logic is_zero;
	} raw_result_s;

	// Delivered result plus exception flags
	typedef struct packed {
		logic valid;
		logic sign;
		logic [EXP_W-1:0] exp;
		logic [FRAC_W-1:0] frac;
		logic underflow;
		logic overflow;
	} fixed_result_s;
endpackage

// [design/range_classify.sv]
/*
 Classifies a raw float result as underflow, overflow or in range.
 Assumes a signed two's complement biased exponent on the input.
*/
`timescale 1ns/1ps
module range_classify
	import float_range_pkg::*;
(
	// Raw result
	input wire raw_result_s raw,
	// Classification
	output logic under,
	output logic over
);
	// Zero results never count as out of range
	assign under = raw.valid && !raw.is_zero &&
		($signed(raw.exp) <= $signed(11'h000));
	assign over = raw.valid && !raw.is_zero &&
		($signed(raw.exp) > $signed(EXP_MAX));
endmodule

// [design/float_range_exception_ctl.sv]
/*
 Floating range exception control: bounds each result's exponent, applies
 the trap-enable policy and produces the trap request.
 Assumes one result per completed operation, from logic on clk_sys.
*/
`timescale 1ns/1ps
// Operation
// - underflow with its trap enabled raises a float interrupt
// - enabled underflow keeps fraction, exponent 400 octal high, zero exact
// - underflow with trap disabled gives exact zero, no interrupt
// - overflow with its trap enabled raises a float interrupt
// - enabled overflow keeps fraction, exponent 400 octal low
// - overflow with trap disabled gives exact zero, no interrupt
// - negative zero stored only together with an interrupt
module float_range_exception_ctl
	import float_range_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Trap enables from the status word
	input wire logic underflow_trap_enable,
	input wire logic overflow_trap_enable,
	// Raw result in
	input wire raw_result_s raw_in,
	// Delivered result out
	output fixed_result_s result_out,
	// Trap request, one cycle high per exception whose trap is enabled
	output logic fp_trap_req
);
	logic under;
	logic over;
	logic trap_nxt;
	fixed_result_s res_nxt;
	fixed_result_s result_r;
	logic trap_r;
	logic [EXP_INT_W-1:0] exp_adj;

	range_classify u_classify (
		.raw(raw_in),
		.under(under),
		.over(over)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		exp_adj = raw_in.exp;
		if (under)
			exp_adj = raw_in.exp + EXP_WRAP;
		else if (over)
			exp_adj = raw_in.exp - EXP_WRAP;
		trap_nxt = (under && underflow_trap_enable) || (over && overflow_trap_enable);
		res_nxt.valid = raw_in.valid;
		res_nxt.underflow = under;
		res_nxt.overflow = over;
		res_nxt.sign = raw_in.sign;
		res_nxt.exp = exp_adj[EXP_W-1:0];
		res_nxt.frac = raw_in.frac;
		if (raw_in.is_zero) begin
			// Zero is always delivered exact
			res_nxt.sign = 1'b0;
			res_nxt.exp = '0;
			res_nxt.frac = '0;
		end else if ((under && !underflow_trap_enable) || (over && !overflow_trap_enable)) begin
			res_nxt.sign = 1'b0;
			res_nxt.exp = '0;
			res_nxt.frac = '0;
		end else if (!trap_nxt && exp_adj[EXP_W-1:0] == '0) begin
			// Biased exponent zero reads as zero; without a trap it carries no sign
			res_nxt.sign = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys) begin
		if (srst)
			result_r <= '0;
		else
			result_r <= res_nxt;
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			trap_r <= 1'b0;
		else
			trap_r <= raw_in.valid && trap_nxt;
	end

	assign result_out = result_r;
	assign fp_trap_req = trap_r;

	////////////////////////////////////////////////////////////////////////
	sequence s_under_en;
		raw_in.valid && under && underflow_trap_enable;
	endsequence
	sequence s_over_en;
		raw_in.valid && over && overflow_trap_enable;
	endsequence

	a_under_trap_req: assert property (@(posedge clk_sys) disable iff (srst)
		s_under_en |=> fp_trap_req) else $error("enabled underflow gave no trap");
	a_under_exp_high: assert property (@(posedge clk_sys) disable iff (srst)
		s_under_en |=> result_out.exp == 8'(($past(raw_in.exp) + EXP_WRAP)) &&
		result_out.frac == $past(raw_in.frac)) else $error("underflow exponent wrong");
	a_under_zeroed: assert property (@(posedge clk_sys) disable iff (srst)
		(raw_in.valid && under && !underflow_trap_enable && !over) |=>
		!fp_trap_req && result_out.exp == '0 && result_out.frac == '0 && !result_out.sign)
		else $error("disabled underflow not exact zero");
	a_over_trap_req: assert property (@(posedge clk_sys) disable iff (srst)
		s_over_en |=> fp_trap_req) else $error("enabled overflow gave no trap");
	a_over_exp_low: assert property (@(posedge clk_sys) disable iff (srst)
		s_over_en |=> result_out.exp == 8'(($past(raw_in.exp) - EXP_WRAP)) &&
		result_out.frac == $past(raw_in.frac)) else $error("overflow exponent wrong");
	a_over_zeroed: assert property (@(posedge clk_sys) disable iff (srst)
		(raw_in.valid && over && !overflow_trap_enable) |=>
		!fp_trap_req && result_out.exp == '0 && result_out.frac == '0 && !result_out.sign)
		else $error("disabled overflow not exact zero");
	a_no_neg_zero: assert property (@(posedge clk_sys) disable iff (srst)
		(result_out.valid && result_out.sign && result_out.exp == '0) |-> fp_trap_req)
		else $error("negative zero stored without trap");
	a_single_trap: assert property (@(posedge clk_sys) disable iff (srst)
		fp_trap_req |-> $past(raw_in.valid) && (result_out.underflow || result_out.overflow))
		else $error("trap request without range exception");

	////////////////////////////////////////////////////////////////////////
	// Steps shared by the checks below
	sequence s_zero_in;
		raw_in.valid && raw_in.is_zero;
	endsequence

	sequence s_in_range;
		raw_in.valid && !raw_in.is_zero && !under && !over;
	endsequence

	sequence s_idle_in;
		!raw_in.valid;
	endsequence

	sequence s_exact_zero_out;
		result_out.exp == '0 && result_out.frac == '0 && !result_out.sign;
	endsequence

	sequence s_quiet_out;
		!fp_trap_req && !result_out.underflow && !result_out.overflow;
	endsequence

	////////////////////////////////////////////////////////////////////////
	// Trap only with the matching enable set one cycle earlier
	a_trap_needs_enable: assert property (@(posedge clk_sys) disable iff (srst)
		fp_trap_req |->
		($past(underflow_trap_enable) && result_out.underflow) ||
		($past(overflow_trap_enable) && result_out.overflow))
		else $error("trap request without its enable");

	a_under_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
		s_under_en |=>
		result_out.valid && result_out.underflow && !result_out.overflow)
		else $error("enabled underflow not flagged");

	a_under_sign_kept: assert property (@(posedge clk_sys) disable iff (srst)
		s_under_en |=>
		result_out.sign == $past(raw_in.sign))
		else $error("enabled underflow lost its sign");

	a_over_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
		s_over_en |=>
		result_out.valid && result_out.overflow && !result_out.underflow)
		else $error("enabled overflow not flagged");

	a_over_sign_kept: assert property (@(posedge clk_sys) disable iff (srst)
		s_over_en |=>
		result_out.sign == $past(raw_in.sign))
		else $error("enabled overflow lost its sign");

	// A zero operand result is exact and never an exception
	a_zero_in_exact: assert property (@(posedge clk_sys) disable iff (srst)
		s_zero_in |=>
		s_exact_zero_out ##0 s_quiet_out)
		else $error("zero result not exact");

	a_range_pass: assert property (@(posedge clk_sys) disable iff (srst)
		s_in_range |=>
		!fp_trap_req &&
		result_out.exp == 8'($past(raw_in.exp)) &&
		result_out.frac == $past(raw_in.frac) &&
		result_out.sign == $past(raw_in.sign))
		else $error("in-range result altered");

	a_idle_quiet: assert property (@(posedge clk_sys) disable iff (srst)
		s_idle_in |=>
		!fp_trap_req && !result_out.valid)
		else $error("output without an operation");

	a_valid_follows: assert property (@(posedge clk_sys) disable iff (srst)
		raw_in.valid |=>
		result_out.valid)
		else $error("operation gave no result");

	a_flags_exclusive: assert property (@(posedge clk_sys) disable iff (srst)
		!(result_out.underflow && result_out.overflow))
		else $error("both range flags set");

	// Checked without disable so the cleared state itself is covered
	a_reset_clear: assert property (@(posedge clk_sys)
		srst |=>
		result_out == '0 && !fp_trap_req)
		else $error("reset left outputs active");
endmodule

// [bench/test_float_range_exception_ctl.sv]
/*
 Self-checking bench for the float range exception control block.
 Assumes the package carriers and a one-cycle registered answer.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_float_range_exception_ctl;
	import float_range_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic ue = 1'b0;
	logic oe = 1'b0;
	raw_result_s raw_in = '0;
	fixed_result_s result_out;
	logic fp_trap_req;
	int failures = 0;
	int n_tests = 0;
	integer seed = 32'h041C;
	logic p_v = 1'b0, p_trap = 1'b0, p_uf = 1'b0, p_of = 1'b0, p_dis = 1'b0, p_sign = 1'b0;
	logic [EXP_W-1:0] p_exp;
	logic [FRAC_W-1:0] p_frac;
	float_range_exception_ctl dut (.clk_sys(clk_sys), .srst(srst),
		.underflow_trap_enable(ue), .overflow_trap_enable(oe),
		.raw_in(raw_in), .result_out(result_out), .fp_trap_req(fp_trap_req));
	always #20 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////
	// Model: exponent -399..399 spans both exception regions each run
	task drive;
		int e;
		begin
			raw_in.valid = ($random(seed) % 4) != 0;
			raw_in.sign = $random(seed);
			raw_in.frac = 55'({$random(seed), $random(seed)});
			e = $random(seed) % 400;
			raw_in.exp = 11'(e);
			raw_in.is_zero = ($random(seed) % 8) == 0;
			ue = $random(seed);
			oe = $random(seed);
			p_v = raw_in.valid;
			p_uf = !raw_in.is_zero && e <= 0;
			p_of = !raw_in.is_zero && e > 255;
			p_trap = p_v && ((p_uf && ue) || (p_of && oe));
			p_dis = raw_in.is_zero || (p_uf && !ue) || (p_of && !oe);
			p_sign = p_dis ? 1'b0 : raw_in.sign;
			p_exp = p_dis ? 8'h00 : 8'(p_uf ? e + 256 : (p_of ? e - 256 : e));
			p_frac = p_dis ? 55'h0 : raw_in.frac;
		end
	endtask
	task check_prev;
		begin
			`CHK("valid", p_v, result_out.valid)
			`CHK("trap", p_trap, fp_trap_req)
			if (p_v) begin
				`CHK("sign", p_sign, result_out.sign)
				`CHK("exp", p_exp, result_out.exp)
				`CHK("frac", p_frac, result_out.frac)
				if (p_dis) begin
					`CHK("zero", 1'b1, result_out[FRAC_W+EXP_W+1:2] == '0)
				end
				`CHK("flags", {p_uf, p_of}, {result_out.underflow, result_out.overflow})
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, failures);
			if (failures == 0 && n_tests > 0) begin
				$display("Test passed");
			end else begin
				$display("Test failed");
			end
			$finish;
		end
	endtask
	initial begin
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_sys);
		end
		#1 `CHK("reset", 1'b1, result_out == '0 && fp_trap_req == 1'b0)
		srst = 1'b0;
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk_sys);
			#1 check_prev();
			drive();
		end
		tally_and_finish();
	end
endmodule
